// ===== common/dag_pkg.sv
/*
  shared constants for the dma channel address generator: register offsets,
  field positions, reset values and addressing mode encodings.
  assumes a 16-bit register port with word-indexed offsets.
*/
package dag_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STA    = 4'h1;
  localparam logic [3:0] OFF_STB    = 4'h2;
  localparam logic [3:0] OFF_CNT    = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK   = 4'h5;
  // control register field positions
  localparam int CTRL_EN_BIT    = 15;
  localparam int CTRL_SIZE_BIT  = 14;
  localparam int CTRL_DIR_BIT   = 13;
  localparam int CTRL_HALF_BIT  = 12;
  localparam int CTRL_ADDR_MODE_SEL_LO  = 4;
  localparam int CTRL_ADDR_MODE_SEL_HI  = 5;
  localparam int CTRL_OPMODE_LO = 0;
  localparam int CTRL_OPMODE_HI = 1;
  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] STA_RST   = 16'h0000;
  localparam logic [9:0]  CNT_RST   = 10'h000;
  localparam logic [1:0]  MASK_RST  = 2'h0;
  // addressing modes
  localparam logic [1:0] ADDR_MODE_SEL_INC   = 2'h0;
  localparam logic [1:0] ADDR_MODE_SEL_FIXED = 2'h1;
  // operating modes: bit 0 one-shot, bit 1 alternating buffers
  localparam int OPM_ONESHOT_BIT  = 0;
  localparam int OPM_PINGPONG_BIT = 1;
  // address steps
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  // status bit positions
  localparam int ST_HALF_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  // channel states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dag_state_t;
endpackage

// ===== rtl/dag_sticky.sv
/*
  one sticky status bit: set by a hardware event, cleared by a read.
  assumes event and clear are synchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dag_sticky (
  // clock and control
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clkEn,
  // set and clear
  input  wire logic setEvt,
  input  wire logic clrRd,
  // state
  output logic      flag
);
  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (clkEn) begin
      flag <= setEvt | (flag & ~clrRd);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dag_channel.sv
/*
  one dma channel address generator with control, start offsets, count,
  status and mask registers on a plain register port.
  assumes the peripheral request, its address and transfer-done strobe are
  synchronous to clock, and the memory side accepts one address per element.
  a channel disabled in mid-element still waits for that element's done
  strobe, so the memory request never hangs high after a stop.
*/
// The implementer's own choices: the plain strobed port and the register offsets.
// Functional notes
// - after reset the addressing mode field is 00, post-increment
// - post-increment starts at selected start offset, advances per element
// - start offset reads give latest transfer offset; programmed value kept
// - mode 01 keeps the memory address fixed
// - switching to fixed mode keeps the current working address
// - mode 1x selects peripheral-indirect regardless of the low bit
// - indirect mode still moves data, counts and raises interrupts
// - indirect offset is base OR zero-extended peripheral address
// - indirect reads of start offset return the combined offset
// - outside indirect mode the request address is ignored
// - indirect mode follows the programmed direction both ways
// - indirect mode works with every operating mode
// - increment by 2 for words and 1 for bytes
`timescale 1ns/100ps
`default_nettype none
module dag_channel (
  // clock and control
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // peripheral request side
  input  wire logic        perReq,
  input  wire logic [15:0] perAddr,
  // memory side
  input  wire logic        xferDone,
  output logic             memReq,
  output logic      [15:0] memAddr,
  output logic             memWrite,
  output logic             memByte,
  // interrupt
  output logic             irq
);
  // registers
  logic [15:0] ctrl_reg;
  logic [15:0] staProg_reg;
  logic [15:0] stbProg_reg;
  logic [9:0]  cnt_reg;
  logic [1:0]  mask_reg;
  logic [15:0] work_reg;
  logic [15:0] work_next;
  logic [15:0] lastA_reg;
  logic [15:0] lastB_reg;
  logic [9:0]  done_reg;
  logic        bufB_reg;
  logic        busy_reg;
  dag_pkg::dag_state_t state_reg;
  logic [1:0]  status;
  logic        enPrev_reg;

  // control field decode
  wire logic       chanEn   = ctrl_reg[dag_pkg::CTRL_EN_BIT];
  wire logic       sizeByte = ctrl_reg[dag_pkg::CTRL_SIZE_BIT];
  wire logic       dirToPer = ctrl_reg[dag_pkg::CTRL_DIR_BIT];
  wire logic       halfIrq  = ctrl_reg[dag_pkg::CTRL_HALF_BIT];
  wire logic [1:0] addr_mode_sel    = ctrl_reg[dag_pkg::CTRL_ADDR_MODE_SEL_HI:dag_pkg::CTRL_ADDR_MODE_SEL_LO];
  wire logic [1:0] opMode   = ctrl_reg[dag_pkg::CTRL_OPMODE_HI:dag_pkg::CTRL_OPMODE_LO];
  wire logic       oneShot  = opMode[dag_pkg::OPM_ONESHOT_BIT];
  wire logic       pingPong = opMode[dag_pkg::OPM_PINGPONG_BIT];

  // addressing mode selection
  wire logic modeInd   = addr_mode_sel[1];
  wire logic modeFixed = (addr_mode_sel == dag_pkg::ADDR_MODE_SEL_FIXED);
  wire logic [15:0] step = sizeByte ? dag_pkg::STEP_BYTE : dag_pkg::STEP_WORD;
  wire logic [15:0] baseSel = bufB_reg ? stbProg_reg : staProg_reg;

  // effective offset of the element now requested
  wire logic [15:0] indAddr = baseSel | perAddr;
  wire logic [15:0] effAddr = modeInd ? indAddr : work_reg;

  // transfer accounting
  wire logic takeReq  = (state_reg == dag_pkg::ST_RUN) && perReq && !busy_reg;
  wire logic elemDone = busy_reg && xferDone;
  wire logic [9:0] doneInc = done_reg + 10'h001;
  wire logic [10:0] halfPt = ({1'b0, cnt_reg} + 11'h002) >> 1;
  wire logic lastElem = elemDone && (doneInc == cnt_reg + 10'h001);
  wire logic halfHit  = elemDone && ({1'b0, doneInc} == halfPt);
  wire logic evHalf   = halfIrq && halfHit;
  wire logic evDone   = !halfIrq && lastElem;
  wire logic enRise   = chanEn && !enPrev_reg;
  wire logic stopRun  = lastElem && oneShot && (!pingPong || bufB_reg);

  // register decode
  wire logic wrCtrl = regWr && (regAddr == dag_pkg::OFF_CTRL);
  wire logic wrSta  = regWr && (regAddr == dag_pkg::OFF_STA);
  wire logic wrStb  = regWr && (regAddr == dag_pkg::OFF_STB);
  wire logic wrCnt  = regWr && (regAddr == dag_pkg::OFF_CNT);
  wire logic wrMask = regWr && (regAddr == dag_pkg::OFF_MASK);
  wire logic rdStat = regRd && (regAddr == dag_pkg::OFF_STATUS);
  wire logic [15:0] rdMux =
      (regAddr == dag_pkg::OFF_CTRL)   ? ctrl_reg :
      (regAddr == dag_pkg::OFF_STA)    ? lastA_reg :
      (regAddr == dag_pkg::OFF_STB)    ? lastB_reg :
      (regAddr == dag_pkg::OFF_CNT)    ? {6'h00, cnt_reg} :
      (regAddr == dag_pkg::OFF_STATUS) ? {14'h0000, status} :
      (regAddr == dag_pkg::OFF_MASK)   ? {14'h0000, mask_reg} : 16'h0000;

  // working address next value
  always_comb begin
    work_next = work_reg;
    if (enRise) begin
      work_next = staProg_reg;
    end else if (lastElem) begin
      work_next = (pingPong && !bufB_reg) ? stbProg_reg : staProg_reg;
    end else if (elemDone && !modeInd && !modeFixed) begin
      work_next = work_reg + step;
    end else begin
      work_next = work_reg;
    end
  end

  // software-written configuration
  // the programmed start offsets are only ever written by software, so
  // a reload at a new buffer always finds the value that was programmed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg    <= dag_pkg::CTRL_RST;
      staProg_reg <= dag_pkg::STA_RST;
      stbProg_reg <= dag_pkg::STA_RST;
      cnt_reg     <= dag_pkg::CNT_RST;
      mask_reg    <= dag_pkg::MASK_RST;
    end else if (clkEn) begin
      // software write wins over the one-shot auto stop
      if (wrCtrl) begin
        ctrl_reg <= regWrData;
      end else if (stopRun) begin
        ctrl_reg[dag_pkg::CTRL_EN_BIT] <= 1'b0;
      end
      // programmed bases, never touched by address updates
      if (wrSta) begin
        staProg_reg <= regWrData;
      end
      if (wrStb) begin
        stbProg_reg <= regWrData;
      end
      // element count and interrupt mask
      if (wrCnt) begin
        cnt_reg <= regWrData[9:0];
      end
      if (wrMask) begin
        mask_reg <= regWrData[1:0];
      end
    end
  end

  // channel state, working address and latest offsets
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg  <= dag_pkg::ST_IDLE;
      work_reg   <= dag_pkg::STA_RST;
      lastA_reg  <= dag_pkg::STA_RST;
      lastB_reg  <= dag_pkg::STA_RST;
      done_reg   <= dag_pkg::CNT_RST;
      bufB_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      enPrev_reg <= 1'b0;
    end else if (clkEn) begin
      // enable history for the rising-edge reload
      enPrev_reg <= chanEn;
      work_reg   <= work_next;
      // latest offsets: a software write seeds them, each take updates
      if (wrSta) begin
        lastA_reg <= regWrData;
      end else if (takeReq && !bufB_reg) begin
        lastA_reg <= effAddr;
      end
      if (wrStb) begin
        lastB_reg <= regWrData;
      end else if (takeReq && bufB_reg) begin
        lastB_reg <= effAddr;
      end
      // run control; an element in flight is finished even when stopped
      case (state_reg)
        dag_pkg::ST_IDLE: begin
          if (elemDone) begin
            busy_reg <= 1'b0;
          end
          if (enRise) begin
            state_reg <= dag_pkg::ST_RUN;
            done_reg  <= dag_pkg::CNT_RST;
            bufB_reg  <= 1'b0;
          end
        end
        dag_pkg::ST_RUN: begin
          if (!chanEn || stopRun) state_reg <= dag_pkg::ST_IDLE;
          if (takeReq) busy_reg <= 1'b1;
          else if (elemDone) busy_reg <= 1'b0;
          if (lastElem) begin
            done_reg <= dag_pkg::CNT_RST;
            bufB_reg <= pingPong ? !bufB_reg : 1'b0;
          end else if (elemDone) begin
            done_reg <= doneInc;
          end
        end
        default: state_reg <= dag_pkg::ST_IDLE;
      endcase
    end
  end

  // memory side outputs, held while an element is in flight
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      memReq   <= 1'b0;
      memAddr  <= dag_pkg::STA_RST;
      memWrite <= 1'b0;
      memByte  <= 1'b0;
    end else if (clkEn) begin
      if (takeReq) begin
        memReq   <= 1'b1;
        memAddr  <= effAddr;
        memWrite <= !dirToPer;
        memByte  <= sizeByte;
      end else if (elemDone) begin
        memReq <= 1'b0;
      end
    end
  end

  // sticky status bits: half and full block
  dag_sticky uHalf (
    .clock  (clock),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .setEvt (evHalf),
    .clrRd  (rdStat),
    .flag   (status[dag_pkg::ST_HALF_BIT])
  );
  dag_sticky uDone (
    .clock  (clock),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .setEvt (evDone),
    .clrRd  (rdStat),
    .flag   (status[dag_pkg::ST_DONE_BIT])
  );

  // read data one cycle after the strobe; masked interrupt level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
      irq       <= 1'b0;
    end else if (clkEn) begin
      regRdData <= regRd ? rdMux : 16'h0000;
      irq       <= |(status & mask_reg);
    end
  end
endmodule
`default_nettype wire

// ===== test/dag_partner.sv
/* peripheral and memory model for the address generator.
   assumes go is a one-cycle pulse from the bench. */
`timescale 1ns/100ps
`default_nettype none
module dag_partner (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // bench control
  input  wire logic        go,
  input  wire logic [15:0] addrIn,
  input  wire logic [3:0]  slow,
  output logic             busy,
  // block side
  output logic             perReq,
  output logic      [15:0] perAddr,
  input  wire logic        memReq,
  output logic             xferDone
);
  logic [1:0] state_reg;
  logic [3:0] cnt_reg;
  assign busy = (state_reg != 2'h0);
  // request with its address, then finish after slow cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= 2'h0;
      perReq    <= 1'b0;
      perAddr   <= 16'h0000;
      xferDone  <= 1'b0;
    end else begin
      case (state_reg)
        2'h0: begin
          xferDone <= 1'b0;
          perAddr  <= go ? addrIn : ~perAddr; // idle address churns
          perReq   <= go;
          if (go) state_reg <= 2'h1;
        end
        2'h1: if (memReq) begin
          perReq    <= 1'b0;
          cnt_reg   <= slow;
          state_reg <= 2'h2;
        end
        2'h2: if (cnt_reg == 4'h0) begin
          xferDone  <= 1'b1;
          state_reg <= 2'h3;
        end else cnt_reg <= cnt_reg - 4'h1;
        default: begin
          xferDone  <= 1'b0;
          state_reg <= 2'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/dag_channel_checker.sv
/* port checker for the address generator channel.
   assumes one clock and a synchronous low reset. */
`timescale 1ns/100ps
`default_nettype none
module dag_channel_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clkEn,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // link and interrupt
  input wire logic        perReq,
  input wire logic [15:0] perAddr,
  input wire logic        xferDone,
  input wire logic        memReq,
  input wire logic [15:0] memAddr,
  input wire logic        memWrite,
  input wire logic        memByte,
  input wire logic        irq
);
  logic [15:0] ctrl_reg;
  logic [15:0] base_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow of control and start offset writes
  always_ff @(posedge clock) begin
    if (!rst_n) ctrl_reg <= 16'h0000;
    else if (clkEn && regWr && regAddr == dag_pkg::OFF_CTRL) ctrl_reg <= regWrData;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) base_reg <= 16'h0000;
    else if (clkEn && regWr && regAddr == dag_pkg::OFF_STA) base_reg <= regWrData;
  end
  sequence elemWait;
    memReq && !xferDone;
  endsequence
  sequence elemEnd;
    memReq && xferDone;
  endsequence
  reset_quiet_a: assert property ($rose(rst_n) |-> !memReq && !irq)
    else $error("outputs active after reset");
  read_quiet_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside read slot");
  req_hold_a: assert property (elemWait |=> memReq)
    else $error("request dropped early");
  req_drop_a: assert property (elemEnd |=> !memReq)
    else $error("request kept after done");
  attr_stable_a: assert property (elemWait |=> $stable(memAddr) && $stable(memByte))
    else $error("element changed in flight");
  take_cause_a: assert property ($rose(memReq) |-> $past(perReq))
    else $error("element without request");
  drop_cause_a: assert property ($fell(memReq) |-> $past(xferDone))
    else $error("element ended without done");
  indirect_addr_a: assert property ($rose(memReq) && ctrl_reg[dag_pkg::CTRL_ADDR_MODE_SEL_HI]
    |-> memAddr == (base_reg | $past(perAddr))) else $error("indirect offset wrong");
  attr_dir_a: assert property ($rose(memReq)
    |-> memWrite == !ctrl_reg[dag_pkg::CTRL_DIR_BIT] && memByte == ctrl_reg[dag_pkg::CTRL_SIZE_BIT])
    else $error("attributes wrong");
endmodule
bind dag_channel dag_channel_checker u_chk (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .perReq(perReq), .perAddr(perAddr), .xferDone(xferDone),
  .memReq(memReq), .memAddr(memAddr), .memWrite(memWrite), .memByte(memByte), .irq(irq));
`default_nettype wire

// ===== test/dma_channel_address_generator_test.sv
/* self-checking bench for the address generator channel.
   assumes the partner model answers every element. */
`timescale 1ns/100ps
`default_nettype none
module dma_channel_address_generator_test;
  logic clock, rst_n, regWr, regRd, go, busy;
  logic perReq, xferDone, memReq, memWrite, memByte, irq;
  logic [3:0]  regAddr, slow;
  logic [15:0] regWrData, regRdData, addrIn, perAddr, memAddr, v;
  int err_count, cmp_count;
  dag_channel u_dut (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .perReq(perReq), .perAddr(perAddr), .xferDone(xferDone), .memReq(memReq),
    .memAddr(memAddr), .memWrite(memWrite), .memByte(memByte), .irq(irq));
  dag_partner u_par (.clock(clock), .rst_n(rst_n), .go(go), .addrIn(addrIn),
    .slow(slow), .busy(busy), .perReq(perReq), .perAddr(perAddr), .memReq(memReq),
    .xferDone(xferDone));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  // one element through the partner, address and attributes judged
  task automatic elem(input logic [15:0] pa, exp, input logic [1:0] attr);
    int n;
    @(posedge clock);
    go <= 1'b1;
    addrIn <= pa;
    @(posedge clock);
    go <= 1'b0;
    for (n = 0; n < 20 && memReq !== 1'b1; n++) @(posedge clock) #1;
    chk("memAddr", exp, memAddr);
    chk("attr", {14'h0, attr}, {14'h0, memWrite, memByte});
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clock) #1;
  endtask
  task automatic t_reset;
    rd(dag_pkg::OFF_CTRL);
    chk("ctrl", dag_pkg::CTRL_RST, v);
    rd(4'hF);
    chk("unmapped", 16'h0000, v);
  endtask
  task automatic t_inc;
    wr(dag_pkg::OFF_STA, 16'h0100);
    wr(dag_pkg::OFF_CNT, 16'h03FF);
    wr(dag_pkg::OFF_CTRL, 16'h8000);
    for (int i = 0; i < 3; i++) elem(16'hA5A5, 16'h0100 + 16'(2 * i), 2'b10);
    rd(dag_pkg::OFF_STA);
    chk("sta latest", 16'h0104, v);
    wr(dag_pkg::OFF_CTRL, 16'h0000);
    wr(dag_pkg::OFF_CTRL, 16'h8000);
    elem(16'h5A5A, 16'h0100, 2'b10);
    wr(dag_pkg::OFF_CTRL, 16'h0000);
    wr(dag_pkg::OFF_STA, 16'h0301);
    wr(dag_pkg::OFF_CTRL, 16'hC000);
    elem(16'h0000, 16'h0301, 2'b11);
    elem(16'h0000, 16'h0302, 2'b11);
  endtask
  task automatic t_fixed;
    slow <= 4'h3;
    wr(dag_pkg::OFF_CTRL, 16'h0000);
    wr(dag_pkg::OFF_STA, 16'h0200);
    wr(dag_pkg::OFF_CTRL, 16'h8000);
    elem(16'h0000, 16'h0200, 2'b10);
    elem(16'h0000, 16'h0202, 2'b10);
    wr(dag_pkg::OFF_CTRL, 16'h8010);
    elem(16'h0000, 16'h0204, 2'b10);
    elem(16'h0000, 16'h0204, 2'b10);
  endtask
  // indirect modes 10 and 11, one-shot, unmasked then masked
  task automatic t_ind;
    for (int m = 2; m < 4; m++) begin
      wr(dag_pkg::OFF_CTRL, 16'h0000);
      wr(dag_pkg::OFF_STA, 16'h0240);
      wr(dag_pkg::OFF_CNT, 16'h0001);
      wr(dag_pkg::OFF_MASK, (m == 2) ? 16'h0002 : 16'h0000);
      wr(dag_pkg::OFF_CTRL, 16'hA001 | 16'(m << 4));
      elem(16'h0005, 16'h0245, 2'b00);
      rd(dag_pkg::OFF_STA);
      chk("sta indirect", 16'h0245, v);
      elem(16'h0011, 16'h0251, 2'b00);
      repeat (2) @(posedge clock);
      #1 chk("irq", {15'h0, m == 2}, {15'h0, irq});
      rd(dag_pkg::OFF_CTRL);
      chk("ctrl one-shot", 16'h2001 | 16'(m << 4), v);
      rd(dag_pkg::OFF_STATUS);
      chk("status", 16'h0002, v);
      @(posedge clock);
      #1 chk("irq cleared", 16'h0000, {15'h0, irq});
    end
  endtask
  // alternating buffers, one-shot, half-block interrupt
  task automatic t_pingpong;
    wr(dag_pkg::OFF_CTRL, 16'h0000);
    wr(dag_pkg::OFF_STA, 16'h0300);
    wr(dag_pkg::OFF_STB, 16'h0400);
    wr(dag_pkg::OFF_CNT, 16'h0001);
    wr(dag_pkg::OFF_MASK, 16'h0001);
    wr(dag_pkg::OFF_CTRL, 16'h9003);
    elem(16'h0000, 16'h0300, 2'b10);
    elem(16'h0000, 16'h0302, 2'b10);
    elem(16'h0000, 16'h0400, 2'b10);
    elem(16'h0000, 16'h0402, 2'b10);
    repeat (2) @(posedge clock);
    #1 chk("irq half", 16'h0001, {15'h0, irq});
    rd(dag_pkg::OFF_STB);
    chk("stb latest", 16'h0402, v);
    rd(dag_pkg::OFF_STA);
    chk("sta kept", 16'h0302, v);
    rd(dag_pkg::OFF_CTRL);
    chk("ctrl stopped", 16'h1003, v);
    rd(dag_pkg::OFF_STATUS);
    chk("status half", 16'h0001, v);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    go = 1'b0;
    addrIn = 16'h0000;
    slow = 4'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_inc();
    t_fixed();
    t_ind();
    t_pingpong();
    finish_test();
  end
endmodule
`default_nettype wire
